// ### awe_pkg.sv
// Purpose: Constants for the wake event logic
// Assumes: 200 MHz clock, AHB-Lite register access
// Notes:   Register indices; byte address is four times the index
`default_nettype none
package awe_pkg;
   // ***************
   // Register indices
   // ***************
   localparam logic [4:0] IDX_PM1_STS1 = 5'h00;
   localparam logic [4:0] IDX_PM1_STS2 = 5'h01;
   localparam logic [4:0] IDX_PM1_EN1  = 5'h02;
   localparam logic [4:0] IDX_PM1_EN2  = 5'h03;
   localparam logic [4:0] IDX_PM1_CTL1 = 5'h04;
   localparam logic [4:0] IDX_GPE_STS1 = 5'h08;
   localparam logic [4:0] IDX_GPE_EN1  = 5'h09;
   localparam logic [4:0] IDX_PME_STS1 = 5'h0C;
   localparam logic [4:0] IDX_PME_STS2 = 5'h0D;
   localparam logic [4:0] IDX_PME_EN1  = 5'h0E;
   localparam logic [4:0] IDX_PME_EN2  = 5'h0F;
   localparam logic [4:0] IDX_GLOBAL_WAKE_FLAG  = 5'h10;
   localparam logic [4:0] IDX_GLOBAL_WAKE_ENABLE   = 5'h11;
   localparam logic [4:0] IDX_SMI_STS1 = 5'h12;
   localparam logic [4:0] IDX_SMI_EN1  = 5'h14;
   localparam logic [4:0] IDX_SMI_EN2  = 5'h15;
   localparam logic [4:0] IDX_PWR_EN   = 5'h18;
   // ***************
   // Field positions and masks
   // ***************
   localparam int         BIT_PRESS    = 0;
   localparam int         BIT_ALARM    = 2;
   localparam int         BIT_OVR      = 3;
   localparam int         BIT_WAKE     = 7;
   localparam int         BIT_SRC_ALM  = 6;
   localparam int         BIT_DEVINT   = 7;
   localparam int         BIT_SMI2WAKE = 7;
   localparam int         BIT_GPE_SCI  = 0;
   localparam int         BIT_GLOBAL   = 0;
   localparam int         BIT_PWR_BTN  = 7;
   localparam int         ROUTE_LSB    = 1;
   localparam logic [7:0] PM1_STS_MASK = 8'h8D;
   localparam logic [7:0] PM1_EN_MASK  = 8'h0D;
   localparam logic [7:0] CTL1_MASK    = 8'h06;
   localparam logic [7:0] PME1_MASK    = 8'h7F;
   localparam logic [7:0] PME2_MASK    = 8'h07;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   // ***************
   // Timing
   // ***************
   localparam int CLK_MHZ     = 200;
   localparam int TICK_MS     = 500;
   localparam int OVR_MIN_MS  = 4000;
   localparam int OVR_MAX_MS  = 4500;
   localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
   localparam int OVR_TICKS   = OVR_MIN_MS / TICK_MS + 1;
   typedef enum logic [1:0] {
      ROUTE_SERIAL,
      ROUTE_LINE,
      ROUTE_SHARED,
      ROUTE_NONE
   } awe_route_type;
endpackage
`default_nettype wire

// ### awe_wake_event_logic.sv
// Purpose: Wake event collection, SCI/PME/SMI requests, button override
// Assumes: Inputs synchronous to clk; rst is the battery power-on reset
// Notes:   AHB-Lite slave, zero wait states, 8-bit registers in low lanes
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module awe_wake_event_logic
   import awe_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // Clock and battery reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Event sources
   input  wire logic        button_in,
   input  wire logic        system_working,
   input  wire logic        rtc_alarm,
   input  wire logic        alarm_remember,
   input  wire logic        ring_indicator_one_n,
   input  wire logic        ring_indicator_two_n,
   input  wire logic        ring_detect_n,
   input  wire logic        consumer_infrared,
   input  wire logic        keyboard_clock_pin,
   input  wire logic        mouse_clock_pin,
   input  wire logic        gpio_group_irq_one,
   input  wire logic        gpio_group_irq_two,
   input  wire logic        serial_one_receive,
   input  wire logic        infrared_receive_two,
   input  wire logic [7:0]  smi_event,
   // Requests
   output logic             sci_serial_req,
   output logic             sci_irq_line,
   output logic             pme_req_n_out,
   output logic             pme_req_n_oe_n,
   output logic             smi_req,
   output logic             power_on_request_n,
   output logic             power_off_pulse
);
   // ***************
   // State
   // ***************
   typedef struct packed {
      logic [7:0]  pm1_sts;
      logic [7:0]  pm1_en;
      logic [7:0]  pm1_ctl;
      logic [7:0]  general_event_enable_reg;
      logic [7:0]  pme_sts1;
      logic [7:0]  pme_sts2;
      logic [7:0]  pme_en1;
      logic [7:0]  pme_en2;
      logic [7:0]  global_wake_flag;
      logic [7:0]  global_wake_enable;
      logic [7:0]  smi_sts1;
      logic [7:0]  smi_en1;
      logic [7:0]  smi_en2;
      logic [7:0]  pwr_en;
      logic [9:0]  prev;
      logic [31:0] tick_cnt;
      logic [3:0]  half_cnt;
      logic        fired;
      logic [4:0]  dp_idx;
      logic        dp_wr;
      logic [31:0] rdata;
      logic        sci_ser;
      logic        sci_line;
      logic        pme_oe_n;
      logic        smi;
      logic        pwr_on_n;
      logic        pwr_off;
   } awe_state_type;

   awe_state_type s_reg;
   awe_state_type s_next;

   function automatic logic [7:0] rd_byte(input awe_state_type st, input logic [4:0] idx);
      unique case (idx)
         IDX_PM1_STS2: rd_byte = st.pm1_sts;
         IDX_PM1_EN2:  rd_byte = st.pm1_en;
         IDX_PM1_CTL1: rd_byte = st.pm1_ctl;
         IDX_GPE_EN1:  rd_byte = st.general_event_enable_reg;
         IDX_PME_STS1: rd_byte = st.pme_sts1;
         IDX_PME_STS2: rd_byte = st.pme_sts2;
         IDX_PME_EN1:  rd_byte = st.pme_en1;
         IDX_PME_EN2:  rd_byte = st.pme_en2;
         IDX_GLOBAL_WAKE_FLAG:  rd_byte = st.global_wake_flag;
         IDX_GLOBAL_WAKE_ENABLE:   rd_byte = st.global_wake_enable;
         IDX_SMI_STS1: rd_byte = st.smi_sts1;
         IDX_SMI_EN1:  rd_byte = st.smi_en1;
         IDX_SMI_EN2:  rd_byte = st.smi_en2;
         IDX_PWR_EN:   rd_byte = st.pwr_en;
         default:      rd_byte = RESET_BYTE;
      endcase
   endfunction

   // ***************
   // Next state
   // ***************
   logic [7:0]    src1;
   logic [7:0]    src2;
   logic          btn_edge;
   logic          tick;
   logic          held;
   logic          fire;
   logic          wake_ev;
   logic          wr;
   logic [7:0]    wd;
   logic          sci_lvl;
   logic          pme_act;
   logic          smi_wake;
   logic          pme_drive;
   awe_route_type route;

   always_comb begin
      s_next = s_reg;
      wr = s_reg.dp_wr;
      wd = hwdata[7:0];
      btn_edge = button_in & ~s_reg.prev[9];
      src1 = {1'b0, rtc_alarm,
              gpio_group_irq_one & ~s_reg.prev[6],
              (s_reg.prev[5] & ~keyboard_clock_pin) | (s_reg.prev[4] & ~mouse_clock_pin),
              consumer_infrared,
              s_reg.prev[2] & ~ring_detect_n,
              s_reg.prev[1] & ~ring_indicator_two_n,
              s_reg.prev[0] & ~ring_indicator_one_n};
      src2 = {5'h00,
              s_reg.prev[8] & ~infrared_receive_two,
              s_reg.prev[7] & ~serial_one_receive,
              gpio_group_irq_two & ~s_reg.prev[3]};
      s_next.prev = {button_in, infrared_receive_two, serial_one_receive, gpio_group_irq_one,
                     keyboard_clock_pin, mouse_clock_pin, gpio_group_irq_two, ring_detect_n,
                     ring_indicator_two_n, ring_indicator_one_n};

      tick = (s_reg.tick_cnt == 32'(TICK_CYC - 1));
      s_next.tick_cnt = tick ? 32'h0 : s_reg.tick_cnt + 32'h1;
      held = button_in & system_working;
      fire = 1'b0;
      // counts while held, clears on release
      if (!held) begin
         s_next.half_cnt = 4'h0;
         s_next.fired = 1'b0;
      end else if (tick && !s_reg.fired) begin
         s_next.half_cnt = s_reg.half_cnt + 4'h1;
         if (s_next.half_cnt == 4'(OVR_TICKS)) begin
            fire = 1'b1;
            s_next.fired = 1'b1;
         end
      end
      fire = fire & s_reg.pm1_en[BIT_OVR];

      wake_ev = |(src1 & s_reg.pwr_en & PME1_MASK) | (btn_edge & s_reg.pwr_en[BIT_PWR_BTN])
              | (alarm_remember & s_reg.pwr_en[BIT_SRC_ALM]);

      if (wr && s_reg.dp_idx == IDX_PM1_STS2)
         s_next.pm1_sts = s_reg.pm1_sts & ~(wd & PM1_STS_MASK);
      s_next.pm1_sts[BIT_PRESS] = s_next.pm1_sts[BIT_PRESS] | btn_edge;
      s_next.pm1_sts[BIT_ALARM] = s_next.pm1_sts[BIT_ALARM] | rtc_alarm | alarm_remember;
      s_next.pm1_sts[BIT_WAKE] = s_next.pm1_sts[BIT_WAKE] | wake_ev;
      // override flag set, press flag cleared
      if (fire) begin
         s_next.pm1_sts[BIT_OVR] = 1'b1;
         s_next.pm1_sts[BIT_PRESS] = 1'b0;
      end

      if (wr && s_reg.dp_idx == IDX_PME_STS1)
         s_next.pme_sts1 = s_reg.pme_sts1 & ~(wd & PME1_MASK);
      s_next.pme_sts1 = s_next.pme_sts1 | src1;
      if (wr && s_reg.dp_idx == IDX_PME_STS2)
         s_next.pme_sts2 = s_reg.pme_sts2 & ~(wd & PME2_MASK);
      s_next.pme_sts2 = s_next.pme_sts2 | src2;
      if (wr && s_reg.dp_idx == IDX_GLOBAL_WAKE_FLAG)
         s_next.global_wake_flag[BIT_GLOBAL] = s_reg.global_wake_flag[BIT_GLOBAL] & ~wd[BIT_GLOBAL];
      s_next.global_wake_flag[BIT_GLOBAL] = s_next.global_wake_flag[BIT_GLOBAL] | (|src1) | (|src2);
      if (wr && s_reg.dp_idx == IDX_SMI_STS1)
         s_next.smi_sts1 = s_reg.smi_sts1 & ~wd;
      s_next.smi_sts1 = s_next.smi_sts1 | smi_event;

      if (wr) begin
         unique case (s_reg.dp_idx)
            IDX_PM1_EN2:  s_next.pm1_en  = wd & PM1_EN_MASK;
            IDX_PM1_CTL1: s_next.pm1_ctl = wd & CTL1_MASK;
            IDX_GPE_EN1:  s_next.general_event_enable_reg  = {7'h00, wd[BIT_GPE_SCI]};
            IDX_PME_EN1:  s_next.pme_en1 = wd;
            IDX_PME_EN2:  s_next.pme_en2 = wd & PME2_MASK;
            IDX_GLOBAL_WAKE_ENABLE:   s_next.global_wake_enable  = {7'h00, wd[BIT_GLOBAL]};
            IDX_SMI_EN1:  s_next.smi_en1 = wd;
            IDX_SMI_EN2:  s_next.smi_en2 = {wd[BIT_SMI2WAKE], 7'h00};
            IDX_PWR_EN:   s_next.pwr_en  = wd;
            default:      s_next.pwr_en  = s_reg.pwr_en;
         endcase
      end

      // Bus address phase; read data follows any write just made
      s_next.dp_wr = 1'b0;
      s_next.rdata = 32'h0;
      if (hsel && hready && htrans[1]) begin
         if (haddr[31:7] == 25'h0 && hsize == 3'b010) begin
            s_next.dp_idx = haddr[6:2];
            s_next.dp_wr = hwrite;
            if (!hwrite)
               s_next.rdata = {24'h0, rd_byte(s_next, haddr[6:2])};
         end
      end

      // enabled PME sources feed GPE path
      pme_act = |(s_next.pme_sts1 & s_next.pme_en1 & PME1_MASK)
              | (s_next.pme_en1[BIT_DEVINT] & |(s_next.pme_sts2 & s_next.pme_en2));
      s_next.smi = |(s_next.smi_sts1 & s_next.smi_en1);
      // SMI routed into SCI and PME
      smi_wake = s_next.pme_en1[BIT_DEVINT] & s_next.smi_en2[BIT_SMI2WAKE] & s_next.smi;
      sci_lvl = |(s_next.pm1_sts & s_next.pm1_en)
              | (s_next.general_event_enable_reg[BIT_GPE_SCI] & pme_act) | smi_wake;
      route = awe_route_type'(s_next.pm1_ctl[ROUTE_LSB +: 2]);
      s_next.sci_ser = sci_lvl & (route == ROUTE_SERIAL);
      s_next.sci_line = sci_lvl & (route == ROUTE_LINE);
      pme_drive = s_next.global_wake_enable[BIT_GLOBAL]
                & (pme_act | smi_wake | (sci_lvl & (route == ROUTE_SHARED)));
      s_next.pme_oe_n = ~pme_drive;
      s_next.pwr_on_n = ~wake_ev;
      s_next.pwr_off = fire;
   end

   // ***************
   // Registers
   // ***************
   // battery reset restores defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.prev <= 10'h3FF;
         s_reg.pme_oe_n <= 1'b1;
         s_reg.pwr_on_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign sci_serial_req = s_reg.sci_ser;
   assign sci_irq_line = s_reg.sci_line;
   assign pme_req_n_out = 1'b0;
   assign pme_req_n_oe_n = s_reg.pme_oe_n;
   assign smi_req = s_reg.smi;
   assign power_on_request_n = s_reg.pwr_on_n;
   assign power_off_pulse = s_reg.pwr_off;

   // ***************
   // Assertions
   // ***************
   logic [31:0] hold_cyc;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         hold_cyc <= 32'h0;
      else
         hold_cyc <= (button_in && system_working) ? hold_cyc + 32'h1 : 32'h0;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   global_gate_a: assert property (!s_reg.global_wake_enable[BIT_GLOBAL] |-> pme_req_n_oe_n)
      else $error("PME driven with global enable off");
   alarm_pme_a: assert property (s_reg.pme_sts1[BIT_SRC_ALM] && s_reg.pme_en1[BIT_SRC_ALM]
      && s_reg.global_wake_enable[BIT_GLOBAL] |-> !pme_req_n_oe_n)
      else $error("Alarm PME not driven");
   alarm_set_a: assert property (rtc_alarm |=> s_reg.pme_sts1[BIT_SRC_ALM] && s_reg.pm1_sts[BIT_ALARM])
      else $error("Alarm flags not set");
   zero_keep_a: assert property (s_reg.pme_sts1[BIT_SRC_ALM] && !(s_reg.dp_wr
      && s_reg.dp_idx == IDX_PME_STS1 && hwdata[BIT_SRC_ALM]) |=> s_reg.pme_sts1[BIT_SRC_ALM])
      else $error("Alarm flag lost without write one");
   ovr_flags_a: assert property (power_off_pulse |-> s_reg.pm1_sts[BIT_OVR]
      && !s_reg.pm1_sts[BIT_PRESS])
      else $error("Override flags wrong");
   ovr_time_a: assert property ($rose(power_off_pulse) |-> hold_cyc > 32'((OVR_TICKS - 1) * TICK_CYC)
      && hold_cyc <= 32'(OVR_TICKS * TICK_CYC) + 32'h1)
      else $error("Override fired outside window");
   press_sci_a: assert property (s_reg.pm1_sts[BIT_PRESS] && s_reg.pm1_en[BIT_PRESS]
      && s_reg.pm1_ctl[ROUTE_LSB +: 2] == 2'b00 |-> sci_serial_req)
      else $error("Press did not raise SCI");
   sci_level_a: assert property (sci_serial_req && $past(s_reg.pm1_ctl) == s_reg.pm1_ctl
      && !$past(sci_serial_req) |-> $past(s_reg.pm1_sts) != s_reg.pm1_sts || $past(s_reg.pm1_en)
      != s_reg.pm1_en || $past(s_reg.general_event_enable_reg) != s_reg.general_event_enable_reg || s_reg.pme_sts1 != $past(s_reg.pme_sts1)
      || s_reg.pme_sts2 != $past(s_reg.pme_sts2) || s_reg.pme_en1 != $past(s_reg.pme_en1)
      || s_reg.pme_en2 != $past(s_reg.pme_en2) || s_reg.smi != $past(s_reg.smi)
      || s_reg.smi_en2 != $past(s_reg.smi_en2))
      else $error("SCI rose with no cause");
   wake_flag_a: assert property (!power_on_request_n |-> s_reg.pm1_sts[BIT_WAKE])
      else $error("Wake flag not set with power-on");
   smi_sci_a: assert property (smi_req && s_reg.pme_en1[BIT_DEVINT] && s_reg.smi_en2[BIT_SMI2WAKE]
      && s_reg.pm1_ctl[ROUTE_LSB +: 2] == 2'b01 |-> sci_irq_line)
      else $error("SMI did not raise SCI");

   ovr_fire_c: cover property (power_off_pulse);
   pme_drive_c: cover property (!pme_req_n_oe_n);
   sci_line_c: cover property (sci_irq_line);
   wake_c: cover property (!power_on_request_n);
endmodule
`default_nettype wire

// ### awe_host_model.sv
// Purpose: Host chipset side of the wake interface
// Assumes: The PME line carries a pull-up on the host board
// Notes:   Counts one-cycle power requests for the bench
`timescale 1ns/1ps
`default_nettype none
module awe_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Device requests
   input  wire logic pme_req_n_out,
   input  wire logic pme_req_n_oe_n,
   input  wire logic power_on_request_n,
   input  wire logic power_off_pulse,
   // Observed state
   output logic      pme_n,
   output var int    power_on_count,
   output var int    power_off_count
);
   // Pull-up wins whenever the open drain lets go
   assign pme_n = pme_req_n_oe_n ? 1'b1 : pme_req_n_out;

   // Strobes last one cycle, so count them here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_on_count  <= 0;
         power_off_count <= 0;
      end else begin
         if (power_on_request_n === 1'b0) power_on_count <= power_on_count + 1;
         if (power_off_pulse === 1'b1) power_off_count <= power_off_count + 1;
      end
   end
endmodule
`default_nettype wire

// ### test_acpi_wake_event_logic.sv
// Purpose: Self-checking bench for the wake event logic
// Assumes: Short override tick so the long press fits the run
// Notes:   Every scenario starts from a fresh battery reset
`timescale 1ns/1ps
`default_nettype none
module test_acpi_wake_event_logic;
   import awe_pkg::*;
   localparam int TC = 10;
   logic        clk            = 1'b0;
   logic        rst            = 1'b1;
   logic        hsel           = 1'b0;
   logic [31:0] haddr          = 32'h0;
   logic [31:0] hwdata         = 32'h0;
   logic [1:0]  htrans         = 2'h0;
   logic [2:0]  hsize          = 3'h2;
   logic        hwrite         = 1'b0;
   logic        button_in      = 1'b0;
   logic        system_working = 1'b1;
   logic [11:0] ev             = 12'h000;
   logic [7:0]  sm             = 8'h00;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, sci_s, sci_l, pme_out, pme_oe_n, smi_req, pon_n, poff, pme_n;
   int          err_count       = 0;
   int          samples_checked = 0;
   int          pon_cnt, poff_cnt;
   wire logic   hready;
   assign hready = hreadyout;
   always #2.5 clk = ~clk;

   awe_wake_event_logic #(.TICK_CYC(TC)) i_dut (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .button_in(button_in), .system_working(system_working), .rtc_alarm(ev[10]), .alarm_remember(ev[11]),
      .ring_indicator_one_n(~ev[0]), .ring_indicator_two_n(~ev[1]), .ring_detect_n(~ev[2]),
      .consumer_infrared(ev[3]), .keyboard_clock_pin(~ev[4]), .mouse_clock_pin(~ev[6]),
      .gpio_group_irq_one(ev[5]), .gpio_group_irq_two(ev[7]), .serial_one_receive(~ev[8]),
      .infrared_receive_two(~ev[9]), .smi_event(sm), .sci_serial_req(sci_s), .sci_irq_line(sci_l),
      .pme_req_n_out(pme_out), .pme_req_n_oe_n(pme_oe_n), .smi_req(smi_req),
      .power_on_request_n(pon_n), .power_off_pulse(poff));
   awe_host_model i_host (
      .clk(clk), .rst(rst), .pme_req_n_out(pme_out), .pme_req_n_oe_n(pme_oe_n),
      .power_on_request_n(pon_n), .power_off_pulse(poff), .pme_n(pme_n),
      .power_on_count(pon_cnt), .power_off_count(poff_cnt));

   // ****************
   // Bus and check tasks
   // ****************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chb(input string what, input logic seen, input logic exp);
      chk(what, {31'h0, seen}, {31'h0, exp});
   endtask
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (n >= 64) chb("hready", hready, 1'b1);
   endtask
   task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {25'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= 3'h2;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdy();
      q = hrdata;
      chb("hresp", hresp, 1'b0);
   endtask
   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rd(input string what, input logic [4:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(what, q, exp);
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 12'h000;
      @(posedge clk);
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_regs();
      logic [4:0] st [5] = '{IDX_PM1_STS2, IDX_PME_STS1, IDX_PME_STS2, IDX_GLOBAL_WAKE_FLAG, IDX_SMI_STS1};
      for (int i = 0; i < 32; i++) rd("reset value", i[4:0], 32'h0);
      foreach (st[i]) begin
         wr(st[i], 8'hFF);
         rd("status by write", st[i], 32'h0);
      end
      wr(IDX_PM1_EN2, 8'hFF);
      rd("enable positions", IDX_PM1_EN2, {24'h0, PM1_EN_MASK});
      wr(5'h1F, 8'hFF);
      rd("unmapped", 5'h1F, 32'h0);
      $display("done registers");
   endtask
   task automatic t_alarm();
      int p0;
      reset_dut();
      wr(IDX_PWR_EN, 8'h40);
      p0 = pon_cnt;
      pulse(10);
      chb("pme gated", pme_n, 1'b1);
      chb("sci gated", sci_l, 1'b0);
      rd("alarm wake flag", IDX_PME_STS1, 32'h40);
      rd("alarm flags", IDX_PM1_STS2, 32'h84);
      rd("global flag", IDX_GLOBAL_WAKE_FLAG, 32'h01);
      chk("alarm power on", pon_cnt - p0, 32'h1);
      wr(IDX_PME_STS1, 8'h00);
      rd("zero write", IDX_PME_STS1, 32'h40);
      wr(IDX_PME_EN1, 8'h40);
      repeat (2) @(posedge clk);
      chb("global off", pme_n, 1'b1);
      wr(IDX_GLOBAL_WAKE_ENABLE, 8'h01);
      repeat (2) @(posedge clk);
      chb("alarm pme", pme_n, 1'b0);
      wr(IDX_PM1_CTL1, 8'h02);
      wr(IDX_PM1_EN2, 8'h04);
      repeat (2) @(posedge clk);
      chb("late enable", sci_l, 1'b1);
      wr(IDX_PME_STS1, 8'h40);
      wr(IDX_PM1_STS2, 8'h84);
      repeat (2) @(posedge clk);
      chb("pme cleared", pme_n, 1'b1);
      chb("sci cleared", sci_l, 1'b0);
      pulse(11);
      chb("remember sci", sci_l, 1'b1);
      chb("remember no pme", pme_n, 1'b1);
      rd("remember pme flag", IDX_PME_STS1, 32'h0);
      $display("done alarm");
   endtask
   task automatic t_button();
      reset_dut();
      wr(IDX_PM1_EN2, 8'h01);
      wr(IDX_GLOBAL_WAKE_ENABLE, 8'h01);
      button_in <= 1'b1;
      @(posedge clk);
      button_in <= 1'b0;
      rd("press flag", IDX_PM1_STS2, 32'h01);
      for (int r = 0; r < 4; r++) begin
         wr(IDX_PM1_CTL1, {5'h0, r[1:0], 1'b0});
         repeat (2) @(posedge clk);
         chb("route serial", sci_s, r == 0);
         chb("route line", sci_l, r == 1);
         chb("route shared", pme_n, r != 2);
      end
      wr(IDX_PM1_CTL1, 8'h00);
      wr(IDX_PM1_STS2, 8'h01);
      repeat (2) @(posedge clk);
      chb("press cleared", sci_s, 1'b0);
      $display("done button");
   endtask
   task automatic t_override();
      int n;
      int p0;
      reset_dut();
      wr(IDX_PM1_EN2, 8'h08);
      p0 = poff_cnt;
      for (int k = 0; k < 2; k++) begin
         button_in <= 1'b1;
         repeat (6 * TC) @(posedge clk);
         button_in <= 1'b0;
         repeat (2) @(posedge clk);
      end
      chk("release clears timer", poff_cnt - p0, 32'h0);
      button_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (poff !== 1'b1 && n < 12 * TC);
      chb("override window", (n >= 8 * TC + 1) && (n <= 9 * TC + 2), 1'b1);
      repeat (3 * TC) @(posedge clk);
      chk("one power off", poff_cnt - p0, 32'h1);
      rd("override flags", IDX_PM1_STS2, 32'h08);
      button_in      <= 1'b0;
      system_working <= 1'b0;
      repeat (2) @(posedge clk);
      button_in <= 1'b1;
      repeat (12 * TC) @(posedge clk);
      chk("asleep no override", poff_cnt - p0, 32'h1);
      button_in      <= 1'b0;
      system_working <= 1'b1;
      $display("done override");
   endtask
   task automatic t_sources();
      int         p0;
      logic [4:0] sidx;
      logic [3:0] pos [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h0, 4'h1, 4'h2};
      reset_dut();
      wr(IDX_PME_EN1, 8'hFF);
      wr(IDX_PME_EN2, 8'h07);
      wr(IDX_GLOBAL_WAKE_ENABLE, 8'h01);
      wr(IDX_GPE_EN1, 8'h01);
      wr(IDX_PM1_CTL1, 8'h02);
      wr(IDX_PWR_EN, 8'h7F);
      for (int i = 0; i < 10; i++) begin
         p0 = pon_cnt;
         sidx = (i < 7) ? IDX_PME_STS1 : IDX_PME_STS2;
         pulse(i);
         chb("source pme", pme_n, 1'b0);
         chb("gpe sci", sci_l, 1'b1);
         rd("source flag", sidx, 32'h1 << pos[i]);
         chk("power on", pon_cnt - p0, (i < 7) ? 32'h1 : 32'h0);
         rd("wake flag", IDX_PM1_STS2, (i < 7) ? 32'h80 : 32'h0);
         wr(sidx, 8'h01 << pos[i]);
         wr(IDX_PM1_STS2, 8'h80);
         repeat (2) @(posedge clk);
         chb("source released", pme_n, 1'b1);
      end
      $display("done sources");
   endtask
   task automatic t_smi();
      reset_dut();
      wr(IDX_SMI_EN1, 8'hFF);
      sm <= 8'h08;
      @(posedge clk);
      sm <= 8'h00;
      repeat (2) @(posedge clk);
      chb("smi level", smi_req, 1'b1);
      wr(IDX_PME_EN1, 8'h80);
      wr(IDX_GLOBAL_WAKE_ENABLE, 8'h01);
      wr(IDX_PM1_CTL1, 8'h02);
      repeat (2) @(posedge clk);
      chb("smi pme gated", pme_n, 1'b1);
      chb("smi sci gated", sci_l, 1'b0);
      wr(IDX_SMI_EN2, 8'h80);
      repeat (2) @(posedge clk);
      chb("smi pme", pme_n, 1'b0);
      chb("smi sci", sci_l, 1'b1);
      wr(IDX_SMI_STS1, 8'h08);
      repeat (2) @(posedge clk);
      chb("smi cleared", sci_l, 1'b0);
      $display("done smi");
   endtask

   // ****************
   // Run and verdict
   // ****************
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      reset_dut();
      t_regs();
      t_alarm();
      t_button();
      t_override();
      t_sources();
      t_smi();
      test_done();
   end
   // Whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("timeout waiting for tests");
      test_done();
   end
endmodule
`default_nettype wire
